/* File: rtl/gpio_port_pkg.sv */
// Package with register map, field layouts, reset values and modes of the GPIO port.
package gpio_port_pkg;

    // Register byte addresses on the APB bus.
    localparam logic [7:0] ADDR_DATA_LATCH   = 8'h00;
    localparam logic [7:0] ADDR_DIRECTION    = 8'h04;
    localparam logic [7:0] ADDR_MODE_OPTION  = 8'h08;
    localparam logic [7:0] ADDR_SENSITIVITY  = 8'h0c;
    localparam logic [7:0] ADDR_GROUP_MASK   = 8'h10;
    localparam logic [7:0] ADDR_ALT_STATUS   = 8'h14;

    // Reset values.
    localparam logic [7:0] RST_DATA_LATCH    = 8'h00;
    localparam logic [7:0] RST_DIRECTION     = 8'h00;
    localparam logic [7:0] RST_MODE_OPTION   = 8'h00;
    localparam logic [2:0] RST_SENSITIVITY   = 3'h0;
    localparam logic [7:0] RST_GROUP_MASK    = 8'h0f;

    // Sensitivity register fields: bits 1:0 sense code, bit 2 polarity invert.
    localparam int SENSE_LO_POS  = 0;
    localparam int SENSE_HI_POS  = 1;
    localparam int POLARITY_POS  = 2;

    // Sense encodings of the two-bit field.
    typedef enum logic [1:0]
    {
        SENSE_FALL_LOW = 2'b00,
        SENSE_RISE     = 2'b01,
        SENSE_FALL     = 2'b10,
        SENSE_BOTH     = 2'b11
    } sense_type;

    // Pin mode as {direction, option}.
    typedef enum logic [1:0]
    {
        MODE_IN_FLOAT  = 2'b00,
        MODE_IN_PULLUP = 2'b01,
        MODE_OUT_OD    = 2'b10,
        MODE_OUT_PP    = 2'b11
    } pin_mode_type;

    // Synchroniser depth for pin inputs.
    localparam int SYNC_STAGES = 2;

endpackage

/* File: rtl/gpio_port.sv */
// GPIO port with per-pin modes, alternate functions and grouped external interrupt request.
`timescale 1ns/1ps

module gpio_port
    import gpio_port_pkg::*;
#(
    parameter int PIN_COUNT = 8
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [PIN_COUNT-1:0] pin_in,
    output logic      [PIN_COUNT-1:0] pin_out,
    output logic      [PIN_COUNT-1:0] pin_oe,
    output logic      [PIN_COUNT-1:0] pin_pullup_en,
    input  wire logic [PIN_COUNT-1:0] alt_enable,
    input  wire logic [PIN_COUNT-1:0] alt_out_enable,
    input  wire logic [PIN_COUNT-1:0] alt_out,
    input  wire logic [PIN_COUNT-1:0] alt_open_drain,
    output logic      [PIN_COUNT-1:0] alt_in,
    input  wire logic                 vector_fetch,
    output logic                      ext_int_request
);

    // Software registers. The group mask selects the pins that belong to this
    // request vector; pins outside it never reach the request latch.
    logic [PIN_COUNT-1:0] port_data_latch_ff;
    logic [PIN_COUNT-1:0] port_direction_select_ff;
    logic [PIN_COUNT-1:0] port_mode_option_ff;
    logic [2:0]           ext_int_sensitivity_control_ff;
    logic [PIN_COUNT-1:0] group_pin_mask_ff;

    // Pin synchroniser and detection state; the fill marker shows how many stages of
    // the pin pipeline already hold a real pin level.
    logic [PIN_COUNT-1:0] pin_meta_ff;
    logic [SYNC_STAGES:0] sync_fill_ff;
    logic [PIN_COUNT-1:0] pin_sync_ff;
    logic [PIN_COUNT-1:0] pin_prev_ff;
    logic                 request_ff;
    logic                 nxt_request;
    logic [31:0]          prdata_ff;
    logic [31:0]          nxt_prdata;

    // Bus decode. Only the exact word address of a register hits it.
    // Every other address, misaligned ones included, falls through to the refusal.
    wire                  bus_access  = psel & penable;
    wire                  bus_write   = bus_access & pwrite;
    wire                  hit_data    = (paddr == ADDR_DATA_LATCH);
    wire                  hit_dir     = (paddr == ADDR_DIRECTION);
    wire                  hit_opt     = (paddr == ADDR_MODE_OPTION);
    wire                  hit_sense   = (paddr == ADDR_SENSITIVITY);
    wire                  hit_mask    = (paddr == ADDR_GROUP_MASK);
    wire                  hit_alt     = (paddr == ADDR_ALT_STATUS);
    wire                  hit_any     = hit_data | hit_dir | hit_opt | hit_sense
                                        | hit_mask | hit_alt;
    wire [PIN_COUNT-1:0]  wdata_pins  = pwdata[PIN_COUNT-1:0];

    // Effective per-pin configuration; alternate function takes priority.
    // The peripheral takes over pin by pin, so every selection below is a bitwise
    // mask and never a vector used as one condition for the whole port.
    wire [PIN_COUNT-1:0]  alt_drive   = alt_enable & alt_out_enable;
    wire [PIN_COUNT-1:0]  eff_dir     = alt_drive
                                        | (~alt_enable & port_direction_select_ff);
    wire [PIN_COUNT-1:0]  eff_value   = (alt_drive & alt_out)
                                        | (~alt_drive & port_data_latch_ff);
    wire [PIN_COUNT-1:0]  eff_od      = (alt_drive & alt_open_drain)
                                        | (~alt_drive & ~port_mode_option_ff);

    // Pad drive: low always drives, high drives only in push-pull.
    // Pull-ups serve software input pins only; a pin owned by a peripheral floats.
    assign pin_out       = eff_value;
    assign pin_oe        = eff_dir & (~eff_value | ~eff_od);
    assign pin_pullup_en = ~eff_dir & port_mode_option_ff & ~alt_enable;
    assign alt_in        = pin_sync_ff;

    // Data read: output pins return the latch, input pins the pin or peripheral output.
    wire [PIN_COUNT-1:0]  in_view     = (alt_drive & alt_out)
                                        | (~alt_drive & pin_sync_ff);
    wire [PIN_COUNT-1:0]  data_view   = (port_direction_select_ff & port_data_latch_ff)
                                        | (~port_direction_select_ff & in_view);

    // Interrupt-capable pins: input with option set, not taken by a peripheral.
    // Keeping owned pins out avoids spurious events while a function takes a pin.
    wire [PIN_COUNT-1:0]  int_pins    = ~port_direction_select_ff & port_mode_option_ff
                                        & ~alt_enable & group_pin_mask_ff;
    wire                  polarity    = ext_int_sensitivity_control_ff[POLARITY_POS];
    wire [1:0]            sense       = {ext_int_sensitivity_control_ff[SENSE_HI_POS],
                                         ext_int_sensitivity_control_ff[SENSE_LO_POS]};
    wire [PIN_COUNT-1:0]  lvl         = polarity ? ~pin_sync_ff : pin_sync_ff;
    wire [PIN_COUNT-1:0]  lvl_prev    = polarity ? ~pin_prev_ff : pin_prev_ff;
    wire [PIN_COUNT-1:0]  rise        = lvl & ~lvl_prev;
    wire [PIN_COUNT-1:0]  fall        = ~lvl & lvl_prev;
    wire [PIN_COUNT-1:0]  any_edge    = pin_sync_ff ^ pin_prev_ff;
    wire                  sense_write = bus_write & hit_sense;

    // Per-pin detection per the sense code, before the OR.
    // The polarity bit inverts the levels first, so it turns rise into fall and low
    // into high, while the both-edges code stays the same.
    logic [PIN_COUNT-1:0] pin_event;
    always_comb
    begin
        case (sense_type'(sense))
            SENSE_FALL_LOW: pin_event = fall | ~lvl;
            SENSE_RISE:     pin_event = rise;
            SENSE_FALL:     pin_event = fall;
            SENSE_BOTH:     pin_event = any_edge;
            default:        pin_event = '0;
        endcase
    end

    // Detection is held off until the synchroniser and the history stage carry real
    // pin levels; otherwise a pulled-up pin would look like a rising edge or a low
    // level straight after reset.
    wire                  detect_ready = sync_fill_ff[SYNC_STAGES];
    wire                  group_event = detect_ready & (|(pin_event & int_pins));

    // Request latch. A vector fetch loses to an event in the same cycle, so an edge
    // that arrives while the CPU fetches is not lost. A write of the sensitivity bits
    // is the software discard, so it clears and also blocks a set in that cycle.
    // In the low-level code a pin held low sets the request again after every fetch.
    always_comb
    begin
        nxt_request = request_ff;
        if (vector_fetch || sense_write)
        begin
            nxt_request = 1'b0;
        end
        if (group_event && !sense_write)
        begin
            nxt_request = 1'b1;
        end
    end

    assign ext_int_request = request_ff;

    // Read multiplexer for unmapped addresses returns zero.
    // The sensitivity word shows its three bits and the upper bits read as zero.
    always_comb
    begin
        nxt_prdata = '0;
        if (hit_data)
        begin
            nxt_prdata[PIN_COUNT-1:0] = data_view;
        end
        else if (hit_dir)
        begin
            nxt_prdata[PIN_COUNT-1:0] = port_direction_select_ff;
        end
        else if (hit_opt)
        begin
            nxt_prdata[PIN_COUNT-1:0] = port_mode_option_ff;
        end
        else if (hit_sense)
        begin
            nxt_prdata[2:0] = ext_int_sensitivity_control_ff;
        end
        else if (hit_mask)
        begin
            nxt_prdata[PIN_COUNT-1:0] = group_pin_mask_ff;
        end
        else if (hit_alt)
        begin
            nxt_prdata[PIN_COUNT-1:0] = alt_enable;
        end
    end

    // APB answers in the access phase with zero wait states. Any address that is not
    // one of the register words is refused with pslverr in the access phase.
    assign pready  = 1'b1;
    assign pslverr = bus_access & ~hit_any;
    assign prdata  = prdata_ff;

    // Read data register, loaded during the setup phase. Loading it there lets the
    // slave answer with zero wait states while prdata still comes from a flip-flop,
    // and it holds through the access phase even if a pin moves in that cycle.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            prdata_ff <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata_ff <= nxt_prdata;
        end
    end

    // Pin synchroniser: the first stage feeds only the second. The third stage is the
    // history used by the edge detectors; it never sees a possibly metastable value.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
            pin_prev_ff <= '0;
        end
        else
        begin
            pin_meta_ff <= pin_in;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    // Fill marker: one more stage of the pin pipeline holds a real level each cycle.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            sync_fill_ff <= '0;
        end
        else
        begin
            sync_fill_ff <= {sync_fill_ff[SYNC_STAGES-1:0], 1'b1};
        end
    end

    // Register writes; data writes always land in the latch only. Whether the latch
    // reaches the pad is decided by the direction bit, so software can preload a level
    // before switching the pin to output. Writes to unmapped addresses change nothing,
    // and the alternate status word is read only.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            port_data_latch_ff             <= RST_DATA_LATCH[PIN_COUNT-1:0];
            port_direction_select_ff       <= RST_DIRECTION[PIN_COUNT-1:0];
            port_mode_option_ff            <= RST_MODE_OPTION[PIN_COUNT-1:0];
            ext_int_sensitivity_control_ff <= RST_SENSITIVITY;
            group_pin_mask_ff              <= RST_GROUP_MASK[PIN_COUNT-1:0];
        end
        else if (bus_write)
        begin
            if (hit_data)
            begin
                port_data_latch_ff <= wdata_pins;
            end
            if (hit_dir)
            begin
                port_direction_select_ff <= wdata_pins;
            end
            if (hit_opt)
            begin
                port_mode_option_ff <= wdata_pins;
            end
            if (hit_sense)
            begin
                ext_int_sensitivity_control_ff <= pwdata[2:0];
            end
            if (hit_mask)
            begin
                group_pin_mask_ff <= wdata_pins;
            end
        end
    end

    // Request latch register. Software cannot write it; only a vector fetch or a
    // sensitivity write takes it down.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            request_ff <= 1'b0;
        end
        else
        begin
            request_ff <= nxt_request;
        end
    end

endmodule

/* File: verification/gpio_port_props.sv */
// Concurrent checks on the bus, pad and request ports of the GPIO port.
`timescale 1ns/1ps
module gpio_port_props
    import gpio_port_pkg::*;
#(
    parameter int PIN_COUNT = 8
)
(
    input wire logic                 ref_clk,
    input wire logic                 reset,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [7:0]           paddr,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe,
    input wire logic [PIN_COUNT-1:0] pin_pullup_en,
    input wire logic [PIN_COUNT-1:0] alt_enable,
    input wire logic [PIN_COUNT-1:0] alt_out_enable,
    input wire logic [PIN_COUNT-1:0] alt_out,
    input wire logic [PIN_COUNT-1:0] alt_open_drain,
    input wire logic                 vector_fetch,
    input wire logic                 ext_int_request
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Access phase of a transfer, and a write of the sensitivity control.
    sequence acc_s;
        psel && penable;
    endsequence
    sequence sens_wr_s;
        psel && penable && pwrite && paddr == ADDR_SENSITIVITY;
    endsequence
    // Bus answers.
    unmapped_err_a: assert property (acc_s ##0 paddr > ADDR_ALT_STATUS |->
        pslverr && (pwrite || prdata == '0)) else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc_s ##0 paddr <= ADDR_ALT_STATUS && paddr[1:0] == 2'h0
        |-> pready && !pslverr) else $error("mapped access refused");
    read_hold_a: assert property (acc_s |=> $stable(prdata)) else $error("read data moved");
    // Pad drive under peripheral control and pull-up use.
    alt_pp_a: assert property (alt_enable == '1 && alt_out_enable == '1 && alt_open_drain == '0
        |-> pin_oe == '1 && pin_out == alt_out) else $error("peripheral push-pull drive wrong");
    alt_od_a: assert property (alt_enable == '1 && alt_out_enable == '1 && alt_open_drain == '1
        |-> pin_oe == ~alt_out && (pin_out & pin_oe) == '0) else $error("open-drain drive wrong");
    pullup_in_a: assert property ((pin_pullup_en & (pin_oe | alt_enable)) == '0)
        else $error("pull-up on driven pin");
    // Request latch.
    sense_clr_a: assert property (sens_wr_s |=> !ext_int_request) else $error("request kept");
    req_hold_a: assert property (ext_int_request && !vector_fetch &&
        !(psel && penable && pwrite && paddr == ADDR_SENSITIVITY) |=> ext_int_request)
        else $error("request dropped");
endmodule

/* File: verification/gpio_pad_model.sv */
// Board-side model of the port pads: external drivers, pull-ups and floating lines.
`timescale 1ns/1ps
module gpio_pad_model
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup_en,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_en,
    output logic      [7:0] pin_level
);
    logic [7:0] last_ff = 8'h00;
    wire  [7:0] driven = pin_oe | ext_en | pin_pullup_en;
    // A floating pad without pull-up keeps the inverse of the level last driven on it.
    always_ff @(posedge ref_clk)
    begin
        last_ff <= (pin_level & driven) | (last_ff & ~driven);
    end
    // Device drive wins, then the board driver, then the pull-up.
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup_en | ~last_ff));
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the GPIO port: registers, pad modes, takeover and requests.
`timescale 1ns/1ps
module tb
    import gpio_port_pkg::*;
;
    logic        ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, vector_fetch = 0;
    logic [7:0]  paddr = '0, pin_in, pin_out, pin_oe, pin_pullup_en, alt_in;
    logic [7:0]  ext_val = '0, ext_en = 8'hff, alt_enable = '0, alt_out_enable = '0;
    logic [7:0]  alt_out = '0, alt_open_drain = '0;
    logic [31:0] pwdata = '0, prdata, rdata;
    logic        pready, pslverr, ext_int_request, err;
    int          n_fail = 0, n_tests = 0;
    always #5 ref_clk = ~ref_clk;
    gpio_port DUT (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .alt_enable(alt_enable),
        .alt_out_enable(alt_out_enable), .alt_out(alt_out), .alt_open_drain(alt_open_drain),
        .alt_in(alt_in), .vector_fetch(vector_fetch), .ext_int_request(ext_int_request));
    gpio_pad_model pads (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin_in));
    // Reports the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One APB transfer: setup, then access until pready, then release.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (k >= 16)
        begin
            n_fail++;
            print_verdict();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic ee);
        xfer(1'b0, a, '0);
        chk(rdata, {24'h0, e});
        chk(err, ee);
    endtask
    // Arms a sense code, makes a pad change, then fetches the vector.
    task automatic irq(input logic [2:0] s, input logic [7:0] f, t, input logic e, stay);
        ext_val <= f;
        cyc(4);
        wr(ADDR_SENSITIVITY, {5'h0, s});
        chk(ext_int_request, 1'b0);
        ext_val <= t;
        cyc(4);
        chk(ext_int_request, e);
        vector_fetch <= 1'b1;
        cyc(1);
        vector_fetch <= 1'b0;
        cyc(1);
        chk(ext_int_request, stay);
    endtask
    // Main sequence.
    initial
    begin
        cyc(20);
        reset <= 1'b0;
        cyc(1);
        rd(ADDR_DATA_LATCH, 8'h00, 1'b0);
        rd(ADDR_DIRECTION, RST_DIRECTION, 1'b0);
        rd(ADDR_MODE_OPTION, RST_MODE_OPTION, 1'b0);
        rd(ADDR_GROUP_MASK, RST_GROUP_MASK, 1'b0);
        rd(ADDR_SENSITIVITY, {5'h0, RST_SENSITIVITY}, 1'b0);
        rd(ADDR_ALT_STATUS, 8'h00, 1'b0);
        rd(8'h20, 8'h00, 1'b1);
        $display("test registers done");
        ext_val <= 8'ha5;
        wr(ADDR_DATA_LATCH, 8'h3c);
        rd(ADDR_DATA_LATCH, 8'ha5, 1'b0);
        chk(pin_oe, 8'h00);
        wr(ADDR_MODE_OPTION, 8'h0f);
        chk(pin_pullup_en, 8'h0f);
        ext_en <= 8'h00;
        wr(ADDR_DIRECTION, 8'hff);
        chk(pin_oe, 8'hcf);
        chk(pin_out & pin_oe, 8'h0c);
        rd(ADDR_DATA_LATCH, 8'h3c, 1'b0);
        $display("test modes done");
        wr(ADDR_DIRECTION, 8'h00);
        wr(ADDR_MODE_OPTION, 8'h00);
        ext_en <= 8'hf0;
        ext_val <= 8'h90;
        alt_enable <= 8'hff;
        alt_out_enable <= 8'h0f;
        alt_out <= 8'h5a;
        cyc(3);
        rd(ADDR_DATA_LATCH, 8'h9a, 1'b0);
        rd(ADDR_ALT_STATUS, 8'hff, 1'b0);
        chk({pin_oe, alt_in}, 16'h0f9a);
        ext_en <= 8'h00;
        alt_out_enable <= 8'hff;
        cyc(2);
        chk({pin_oe, pin_out}, 16'hff5a);
        alt_open_drain <= 8'hff;
        cyc(2);
        chk(pin_oe, 8'ha5);
        alt_enable <= 8'h00;
        ext_en <= 8'hff;
        $display("test takeover done");
        wr(ADDR_MODE_OPTION, 8'hff);
        irq(3'h1, 8'h00, 8'h01, 1'b1, 1'b0);
        irq(3'h2, 8'hff, 8'hfe, 1'b1, 1'b0);
        irq(3'h3, 8'h00, 8'h01, 1'b1, 1'b0);
        irq(3'h3, 8'hff, 8'hfe, 1'b1, 1'b0);
        irq(3'h2, 8'h00, 8'h01, 1'b0, 1'b0);
        irq(3'h1, 8'h00, 8'h10, 1'b0, 1'b0);
        irq(3'h0, 8'hff, 8'hfb, 1'b1, 1'b1);
        irq(3'h5, 8'hff, 8'hfe, 1'b1, 1'b0);
        irq(3'h4, 8'h00, 8'h02, 1'b1, 1'b1);
        irq(3'h1, 8'h00, 8'h03, 1'b1, 1'b0);
        irq(3'h6, 8'h00, 8'h01, 1'b1, 1'b0);
        irq(3'h7, 8'hff, 8'hfe, 1'b1, 1'b0);
        $display("test requests done");
        print_verdict();
    end
endmodule
bind gpio_port gpio_port_props #(.PIN_COUNT(PIN_COUNT)) u_props (.ref_clk(ref_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .alt_enable(alt_enable), .alt_out_enable(alt_out_enable),
    .alt_out(alt_out), .alt_open_drain(alt_open_drain), .vector_fetch(vector_fetch),
    .ext_int_request(ext_int_request));
